// ### design/delay_timer.sv
/*
 * Down counter giving a one-cycle done pulse a fixed number of cycles
 * after start. Assumes start and abort come from the same clock domain.
 */
`timescale 1ns/1ns
module delay_timer #(
	parameter int CYCLES = 16,
	parameter int CNT_W = 32
) (
	input wire logic clock, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire logic start, // (re)load the count
	input wire logic abort, // stop without done
	output logic busy, // counting
	output logic done // one-cycle end pulse
);

	localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);

	logic [CNT_W-1:0] count_q;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			count_q <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				busy <= 1'b0;
				count_q <= '0;
			end else if (start) begin
				busy <= 1'b1;
				count_q <= LOAD;
			end else if (busy) begin
				if (count_q <= CNT_W'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
					count_q <= '0;
				end else begin
					count_q <= count_q - CNT_W'(1);
				end
			end
		end
	end

endmodule

// ### design/supply_monitor_one.sv
/*
 * Digital control and status of supply monitor one: threshold select,
 * crossing detection, sticky passage flag, level flag, interrupt or reset
 * request with restart timing, and a local interrupt status block.
 * Assumes an analog comparator giving an asynchronous above-threshold level.
 */
// Notes on behaviour
// - threshold chosen from ten levels by level register
// - condition field picks rise, drop or both
// - type bit: zero non-maskable, one maskable
// - reserved bits read zero, software writes zero
// - writes need the protect write-enable bit; irq status and irq mask writes here do not check it
// - passage flag set on crossing, clear by zero
// - cleared flag reads zero two clocks later
// - level flag zero below, one above or disabled
// - passage flag works only when both enables set
// - level flag follows comparator only when both enabled
// - reset mode holds reset below, timed restart; with restart select set, reset ends after the timer even while below
// - enable bit five, circuit waits settling delay
// - level field bits three to zero, codes four-thirteen
`timescale 1ns/1ns
module supply_monitor_one
	import supply_monitor_pkg::*;
#(
	parameter int SETTLE_CNT = SETTLE_CYCLES,
	parameter int RESTART_CNT = RESTART_CYCLES,
	parameter int CNT_W = 32
) (
	input wire logic clock, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire bus_req_s bus_req, // register access request
	output byte_t rd_data, // read data, cycle after read
	input wire logic cmp_above, // comparator: supply at or above
	output logic detect_enable, // comparator power enable
	output logic [3:0] threshold_level, // selected threshold code
	output logic nmi_req, // non-maskable request pulse
	output logic irq_req, // maskable request pulse
	output logic reset_req, // monitor reset request level
	output logic irq // local interrupt level
);

	typedef enum {RST_IDLE, RST_HOLD, RST_WAIT} rst_state_e;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic hit(input bus_req_s r, input addr_t a);
		return r.addr == a;
	endfunction

	function automatic logic level_legal(input logic [3:0] c);
		return (c >= LEVEL_MIN) && (c <= LEVEL_MAX);
	endfunction

	// ****************************************
	// registers
	// ****************************************
	logic [1:0] cond_q;
	logic type_q;
	logic prot_q;
	logic req_en_q;
	logic cmp_out_en_q;
	logic reset_mode_q;
	logic restart_sel_q;
	logic det_flag_q;
	logic [1:0] clr_pipe_q;
	logic [IRQ_BITS-1:0] irq_stat_q;
	logic [IRQ_BITS-1:0] irq_mask_q;
	logic cmp_meta_q;
	logic cmp_sync_q;
	logic prev_level_q;
	logic prev_active_q;
	logic settled_q;
	logic enable_prev_q;
	rst_state_e rst_state_q;

	logic wr_ok;
	logic active;
	logic rise_evt;
	logic drop_evt;
	logic cross_evt;
	logic settle_done;
	logic restart_done;
	logic restart_start;
	logic restart_abort;
	logic restart_evt;
	logic mon_level;
	logic [IRQ_BITS-1:0] irq_set;

	assign wr_ok = bus_req.wr && prot_q;
	assign active = detect_enable && settled_q && cmp_out_en_q;
	assign mon_level = active ? cmp_sync_q : 1'b1;
	assign rise_evt = active && prev_active_q && !prev_level_q && cmp_sync_q;
	assign drop_evt = active && prev_active_q && prev_level_q && !cmp_sync_q;

	always_comb begin
		case (cond_q)
			COND_RISE: cross_evt = rise_evt;
			COND_DROP: cross_evt = drop_evt;
			COND_BOTH: cross_evt = rise_evt || drop_evt;
			default: cross_evt = 1'b0;
		endcase
	end

	// ****************************************
	// comparator synchroniser
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cmp_meta_q <= 1'b1;
			cmp_sync_q <= 1'b1;
		end else begin
			cmp_meta_q <= cmp_above;
			cmp_sync_q <= cmp_meta_q;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prev_level_q <= 1'b1;
			prev_active_q <= 1'b0;
		end else begin
			prev_level_q <= cmp_sync_q;
			prev_active_q <= active;
		end
	end

	// ****************************************
	// software-written control
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cond_q <= EVENT_CTRL_RESET[1:0];
			type_q <= EVENT_CTRL_RESET[TYPE_BIT];
		end else if (wr_ok && hit(bus_req, EVENT_CTRL_ADDR)) begin
			if (bus_req.wdata[COND_LSB+:2] != COND_BAD) begin
				cond_q <= bus_req.wdata[COND_LSB+:2];
			end
			type_q <= bus_req.wdata[TYPE_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			threshold_level <= LEVEL_RESET;
		end else if (wr_ok && hit(bus_req, LEVEL_ADDR)) begin
			if (level_legal(bus_req.wdata[3:0])) begin
				threshold_level <= bus_req.wdata[3:0];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			detect_enable <= 1'b0;
		end else if (wr_ok && hit(bus_req, CMP_CTRL_ADDR)) begin
			detect_enable <= bus_req.wdata[DETECT_EN_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			req_en_q <= 1'b0;
			cmp_out_en_q <= 1'b0;
			reset_mode_q <= 1'b0;
			restart_sel_q <= 1'b0;
		end else if (wr_ok && hit(bus_req, CTRL_ZERO_ADDR)) begin
			req_en_q <= bus_req.wdata[REQ_EN_BIT];
			cmp_out_en_q <= bus_req.wdata[CMP_OUT_EN_BIT];
			reset_mode_q <= bus_req.wdata[RESET_MODE_BIT];
			restart_sel_q <= bus_req.wdata[RESTART_SEL_BIT];
		end
	end

	// protect register itself is always writable
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prot_q <= 1'b0;
		end else if (bus_req.wr && hit(bus_req, PROTECT_ADDR)) begin
			prot_q <= bus_req.wdata[PROTECT_BIT];
		end
	end

	// ****************************************
	// settling delay after enable
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			enable_prev_q <= 1'b0;
			settled_q <= 1'b0;
		end else begin
			enable_prev_q <= detect_enable;
			if (!detect_enable) begin
				settled_q <= 1'b0;
			end else if (settle_done) begin
				settled_q <= 1'b1;
			end
		end
	end

	delay_timer #(
		.CYCLES(SETTLE_CNT),
		.CNT_W(CNT_W)
	) settle_timer (
		.clock(clock),
		.sys_rst(sys_rst),
		.start(detect_enable && !enable_prev_q),
		.abort(!detect_enable),
		.busy(),
		.done(settle_done)
	);

	// ****************************************
	// passage flag
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			det_flag_q <= 1'b0;
			clr_pipe_q <= 2'h0;
		end else begin
			clr_pipe_q <= {clr_pipe_q[0], 1'b0};
			if (wr_ok && hit(bus_req, STATUS_ADDR) && !bus_req.wdata[DET_BIT]) begin
				clr_pipe_q <= 2'h1;
			end
			if (cross_evt) begin
				det_flag_q <= 1'b1;
				clr_pipe_q <= 2'h0;
			end else if (clr_pipe_q[CLEAR_DELAY_CYCLES-1]) begin
				det_flag_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// interrupt requests
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			nmi_req <= 1'b0;
			irq_req <= 1'b0;
		end else begin
			nmi_req <= cross_evt && req_en_q && !reset_mode_q && !type_q;
			irq_req <= cross_evt && req_en_q && !reset_mode_q && type_q;
		end
	end

	// ****************************************
	// reset request and restart timing
	// ****************************************
	assign restart_start = (rst_state_q == RST_HOLD) && (restart_sel_q ? 1'b1 : cmp_sync_q);
	assign restart_abort = (rst_state_q == RST_WAIT) && !restart_sel_q && !cmp_sync_q;
	assign restart_evt = (rst_state_q == RST_WAIT) && restart_done && !restart_abort;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rst_state_q <= RST_IDLE;
			reset_req <= 1'b0;
		end else begin
			case (rst_state_q)
				RST_IDLE: begin
					if (reset_mode_q && req_en_q && drop_evt) begin
						rst_state_q <= RST_HOLD;
						reset_req <= 1'b1;
					end
				end
				RST_HOLD: begin
					if (restart_start) begin
						rst_state_q <= RST_WAIT;
					end
				end
				RST_WAIT: begin
					if (restart_abort) begin
						rst_state_q <= RST_HOLD;
					end else if (restart_done) begin
						rst_state_q <= RST_IDLE;
						reset_req <= 1'b0;
					end
				end
				default: begin
					rst_state_q <= RST_IDLE;
					reset_req <= 1'b0;
				end
			endcase
		end
	end

	delay_timer #(
		.CYCLES(RESTART_CNT),
		.CNT_W(CNT_W)
	) restart_timer (
		.clock(clock),
		.sys_rst(sys_rst),
		.start(restart_start),
		.abort(restart_abort),
		.busy(),
		.done(restart_done)
	);

	// ****************************************
	// local interrupt status and mask
	// ****************************************
	assign irq_set = {restart_evt, settle_done, cross_evt};

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_stat_q <= IRQ_RESET;
		end else begin
			if (bus_req.wr && hit(bus_req, IRQ_STAT_ADDR)) begin
				irq_stat_q <= (irq_stat_q & ~bus_req.wdata[IRQ_BITS-1:0]) | irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_mask_q <= IRQ_RESET;
		end else if (bus_req.wr && hit(bus_req, IRQ_MASK_ADDR)) begin
			irq_mask_q <= bus_req.wdata[IRQ_BITS-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ****************************************
	// read data
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rd_data <= 8'h00;
		end else if (!bus_req.rd) begin
			rd_data <= 8'h00;
		end else begin
			case (bus_req.addr)
				EVENT_CTRL_ADDR: rd_data <= {5'h00, type_q, cond_q};
				STATUS_ADDR: rd_data <= {6'h00, mon_level, det_flag_q};
				CMP_CTRL_ADDR: rd_data <= 8'(detect_enable) << DETECT_EN_BIT;
				LEVEL_ADDR: rd_data <= {4'h0, threshold_level};
				CTRL_ZERO_ADDR: rd_data <= {restart_sel_q, reset_mode_q, 3'h0,
					cmp_out_en_q, 1'b0, req_en_q};
				PROTECT_ADDR: rd_data <= 8'(prot_q) << PROTECT_BIT;
				IRQ_STAT_ADDR: rd_data <= {5'h00, irq_stat_q};
				IRQ_MASK_ADDR: rd_data <= {5'h00, irq_mask_q};
				default: rd_data <= 8'h00;
			endcase
		end
	end

endmodule

// ### design/supply_monitor_pkg.sv
/*
 * Constants, register map and carrier types for the supply monitor one
 * event logic. Assumes a 250 MHz system clock and a byte-wide register port.
 */
package supply_monitor_pkg;

	typedef logic [31:0] addr_t;
	typedef logic [7:0] byte_t;

	// register port request, one cycle per access
	typedef struct packed {
		addr_t addr;
		byte_t wdata;
		logic wr;
		logic rd;
	} bus_req_s;

	// ****************************************
	// register offsets
	// ****************************************
	localparam addr_t EVENT_CTRL_ADDR = 32'h000800e0;
	localparam addr_t STATUS_ADDR = 32'h000800e1;
	localparam addr_t CMP_CTRL_ADDR = 32'h0008c297;
	localparam addr_t LEVEL_ADDR = 32'h0008c298;
	localparam addr_t CTRL_ZERO_ADDR = 32'h000800d0;
	localparam addr_t PROTECT_ADDR = 32'h000800d4;
	localparam addr_t IRQ_STAT_ADDR = 32'h000800d8;
	localparam addr_t IRQ_MASK_ADDR = 32'h000800d9;

	// ****************************************
	// field positions
	// ****************************************
	localparam int COND_LSB = 0;
	localparam int TYPE_BIT = 2;
	localparam int DET_BIT = 0;
	localparam int MON_BIT = 1;
	localparam int DETECT_EN_BIT = 5;
	localparam int REQ_EN_BIT = 0;
	localparam int CMP_OUT_EN_BIT = 2;
	localparam int RESET_MODE_BIT = 6;
	localparam int RESTART_SEL_BIT = 7;
	localparam int PROTECT_BIT = 3;
	localparam int EV_CROSS_BIT = 0;
	localparam int EV_SETTLED_BIT = 1;
	localparam int EV_RESTART_BIT = 2;
	localparam int IRQ_BITS = 3;

	// event condition codes
	localparam logic [1:0] COND_RISE = 2'h0;
	localparam logic [1:0] COND_DROP = 2'h1;
	localparam logic [1:0] COND_BOTH = 2'h2;
	localparam logic [1:0] COND_BAD = 2'h3;

	// legal threshold codes
	localparam logic [3:0] LEVEL_MIN = 4'h4;
	localparam logic [3:0] LEVEL_MAX = 4'hd;
	localparam int LEVEL_COUNT = 10;

	// ****************************************
	// values after reset
	// ****************************************
	localparam byte_t EVENT_CTRL_RESET = 8'h00;
	localparam logic [3:0] LEVEL_RESET = 4'h4;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 250;
	localparam int SETTLE_TIME_US = 100;
	localparam int RESTART_TIME_US = 1000;
	localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_MHZ;
	localparam int RESTART_CYCLES = RESTART_TIME_US * CLK_MHZ;
	localparam int CLEAR_DELAY_CYCLES = 2;

endpackage

// ### test/supply_comparator_model.sv
/* analog supply comparator model.
   assumes codes 4 to 13 step down in voltage, supply given as a rank. */
`timescale 1ns/1ns
module supply_comparator_model (
	input wire logic [4:0] supply_rank, // supply step, larger is higher
	input wire logic detect_enable, // comparator powered
	input wire logic [3:0] threshold_level, // selected code
	output logic cmp_above // at or above threshold
);
	// unpowered comparator idles high
	assign cmp_above = detect_enable ? (supply_rank >= 5'd17 - {1'b0, threshold_level}) : 1'b1;
endmodule

// ### test/supply_monitor_asserts.sv
/* port checker for supply monitor one.
   assumes binding onto supply_monitor_one, protect bit clear at reset. */
`timescale 1ns/1ns
module supply_monitor_asserts
	import supply_monitor_pkg::*;
(
	input wire logic clock, // clock
	input wire logic sys_rst, // reset
	input wire bus_req_s bus_req, // register port
	input wire byte_t rd_data, // read data
	input wire logic detect_enable, // detect enable
	input wire logic [3:0] threshold_level, // level code
	input wire logic nmi_req, // nmi pulse
	input wire logic irq_req // irq pulse
);
	// ****************************************
	// shadow of write-gating bits
	// ****************************************
	logic prot_q;
	logic en_q;
	logic type_q;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prot_q <= 1'b0;
			en_q <= 1'b0;
			type_q <= 1'b0;
		end else if (bus_req.wr) begin
			if (bus_req.addr == PROTECT_ADDR)
				prot_q <= bus_req.wdata[PROTECT_BIT];
			if (prot_q && bus_req.addr == CTRL_ZERO_ADDR)
				en_q <= bus_req.wdata[REQ_EN_BIT];
			if (prot_q && bus_req.addr == EVENT_CTRL_ADDR)
				type_q <= bus_req.wdata[TYPE_BIT];
		end
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence lvl_wr;
		bus_req.wr && bus_req.addr == LEVEL_ADDR;
	endsequence
	sequence lvl_ok;
		lvl_wr ##0 prot_q && bus_req.wdata[3:0] inside {[LEVEL_MIN:LEVEL_MAX]};
	endsequence
	req_excl_a: assert property (!(nmi_req && irq_req)) else $error("two requests");
	nmi_type_a: assert property (nmi_req |-> !$past(type_q) && $past(en_q))
		else $error("nmi type");
	irq_type_a: assert property (irq_req |-> $past(type_q) && $past(en_q))
		else $error("irq type");
	pulse_one_a: assert property ((nmi_req || irq_req) |=> !(nmi_req || irq_req))
		else $error("long pulse");
	rd_idle_a: assert property (!bus_req.rd |=> rd_data == 8'h00) else $error("rd idle");
	stat_rsv_a: assert property (bus_req.rd && bus_req.addr == STATUS_ADDR
		|=> rd_data[7:2] == 6'h00) else $error("status bits");
	ctrl_rsv_a: assert property (bus_req.rd && bus_req.addr == EVENT_CTRL_ADDR
		|=> rd_data[7:3] == 5'h00 && rd_data[1:0] != COND_BAD) else $error("ctrl bits");
	lvl_prot_a: assert property (lvl_wr ##0 !prot_q |=> $stable(threshold_level))
		else $error("level unprotected");
	lvl_set_a: assert property (lvl_ok |=> threshold_level == $past(bus_req.wdata[3:0]))
		else $error("level write");
	lvl_range_a: assert property (threshold_level inside {[LEVEL_MIN:LEVEL_MAX]})
		else $error("level range");
	det_en_a: assert property (bus_req.wr && bus_req.addr == CMP_CTRL_ADDR && prot_q
		|=> detect_enable == $past(bus_req.wdata[DETECT_EN_BIT])) else $error("detect en");
endmodule

bind supply_monitor_one supply_monitor_asserts i_chk (.clock(clock), .sys_rst(sys_rst),
	.bus_req(bus_req), .rd_data(rd_data), .detect_enable(detect_enable),
	.threshold_level(threshold_level), .nmi_req(nmi_req), .irq_req(irq_req));

// ### test/tb_top.sv
/* self-checking bench for supply monitor one.
   assumes protect bit clear after reset and short settle/restart counts. */
`timescale 1ns/1ns
module tb_top
	import supply_monitor_pkg::*;
;
	typedef struct packed {addr_t wa; byte_t wd; addr_t ra; byte_t exp;} row_s;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	bus_req_s bus_req = '0;
	logic [4:0] supply_rank = 5'd20;
	byte_t rd_data;
	logic cmp_above, detect_enable, nmi_req, irq_req, reset_req, irq;
	logic [3:0] threshold_level;
	int errors = 0, n_compared = 0, cycles = 0, n_nmi = 0, n_irq = 0;
	row_s rows [10] = '{
		'{LEVEL_ADDR, 8'h09, LEVEL_ADDR, 8'h09}, '{LEVEL_ADDR, 8'h03, LEVEL_ADDR, 8'h09},
		'{LEVEL_ADDR, 8'h0e, LEVEL_ADDR, 8'h09}, '{LEVEL_ADDR, 8'h0d, LEVEL_ADDR, 8'h0d},
		'{EVENT_CTRL_ADDR, 8'hff, EVENT_CTRL_ADDR, 8'h04},
		'{EVENT_CTRL_ADDR, 8'h01, EVENT_CTRL_ADDR, 8'h01},
		'{EVENT_CTRL_ADDR, 8'h02, EVENT_CTRL_ADDR, 8'h02},
		'{EVENT_CTRL_ADDR, 8'h00, EVENT_CTRL_ADDR, 8'h00},
		'{CMP_CTRL_ADDR, 8'hff, CMP_CTRL_ADDR, 8'h20}, '{32'h000800e5, 8'hff, 32'h000800e5, 8'h00}};

	supply_monitor_one #(.SETTLE_CNT(8), .RESTART_CNT(10)) i_dut (.clock(clock),
		.sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data), .cmp_above(cmp_above),
		.detect_enable(detect_enable), .threshold_level(threshold_level), .nmi_req(nmi_req),
		.irq_req(irq_req), .reset_req(reset_req), .irq(irq));
	supply_comparator_model i_cmp (.supply_rank(supply_rank), .detect_enable(detect_enable),
		.threshold_level(threshold_level), .cmp_above(cmp_above));

	initial begin
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (!sys_rst) begin
			n_nmi <= n_nmi + int'(nmi_req);
			n_irq <= n_irq + int'(irq_req);
		end
		if (cycles == 3000) begin
			errors = errors + 1;
			end_of_test();
		end
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input byte_t seen, input byte_t exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input addr_t a, input byte_t d);
		@(posedge clock) bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clock) bus_req.wr <= 1'b0;
	endtask
	task automatic rchk(input addr_t a, input byte_t exp);
		@(posedge clock) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock) bus_req.rd <= 1'b0;
		#1 chk(rd_data, exp);
	endtask
	task automatic swing(input logic [4:0] r);
		@(posedge clock) supply_rank <= r;
		repeat (8) @(posedge clock);
	endtask
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		rchk(STATUS_ADDR, 8'h02);
		rchk(LEVEL_ADDR, {4'h0, LEVEL_RESET});
		rchk(EVENT_CTRL_ADDR, EVENT_CTRL_RESET);
		wr(LEVEL_ADDR, 8'h07);
		rchk(LEVEL_ADDR, {4'h0, LEVEL_RESET});
		wr(PROTECT_ADDR, 8'h08);
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			rchk(rows[i].ra, rows[i].exp);
		end
		// drop event as nmi
		wr(IRQ_MASK_ADDR, 8'h01);
		wr(EVENT_CTRL_ADDR, {6'h00, COND_DROP});
		wr(CTRL_ZERO_ADDR, 8'h05);
		repeat (20) @(posedge clock);
		rchk(STATUS_ADDR, 8'h02);
		swing(5'd2);
		chk(byte_t'(n_nmi), 8'h01);
		chk({7'h00, irq}, 8'h01);
		rchk(STATUS_ADDR, 8'h01);
		swing(5'd20);
		rchk(STATUS_ADDR, 8'h03);
		chk(byte_t'(n_nmi), 8'h01);
		wr(STATUS_ADDR, 8'h03);
		rchk(STATUS_ADDR, 8'h03);
		// request enable off before clearing, reads back to back
		wr(CTRL_ZERO_ADDR, 8'h04);
		@(posedge clock) bus_req <= '{STATUS_ADDR, 8'h00, 1'b1, 1'b0};
		@(posedge clock) bus_req <= '{STATUS_ADDR, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		#1 chk(rd_data, 8'h03);
		@(posedge clock);
		#1 chk(rd_data, 8'h03);
		@(posedge clock) bus_req.rd <= 1'b0;
		#1 chk(rd_data, 8'h02);
		// interrupt mask and clear
		rchk(IRQ_STAT_ADDR, 8'h03);
		wr(IRQ_MASK_ADDR, 8'h00);
		@(posedge clock);
		#1 chk({7'h00, irq}, 8'h00);
		wr(IRQ_MASK_ADDR, 8'h01);
		wr(IRQ_STAT_ADDR, 8'h03);
		rchk(IRQ_STAT_ADDR, 8'h00);
		chk({7'h00, irq}, 8'h00);
		// maskable on both crossings
		wr(EVENT_CTRL_ADDR, {5'h00, 1'b1, COND_BOTH});
		wr(CTRL_ZERO_ADDR, 8'h05);
		swing(5'd2);
		swing(5'd20);
		chk(byte_t'(n_irq), 8'h02);
		chk(byte_t'(n_nmi), 8'h01);
		// compare output off: flag frozen, level reads high
		wr(CTRL_ZERO_ADDR, 8'h00);
		wr(STATUS_ADDR, 8'h00);
		swing(5'd2);
		rchk(STATUS_ADDR, 8'h02);
		swing(5'd20);
		// protect cleared
		wr(PROTECT_ADDR, 8'h00);
		wr(LEVEL_ADDR, 8'h05);
		rchk(LEVEL_ADDR, 8'h0d);
		wr(PROTECT_ADDR, 8'h08);
		// reset mode, restart timed from rise
		wr(CTRL_ZERO_ADDR, 8'h45);
		swing(5'd2);
		chk({7'h00, reset_req}, 8'h01);
		@(posedge clock) supply_rank <= 5'd20;
		repeat (5) @(posedge clock);
		chk({7'h00, reset_req}, 8'h01);
		repeat (20) @(posedge clock);
		chk({7'h00, reset_req}, 8'h00);
		// restart timed from drop, released while still low
		wr(CTRL_ZERO_ADDR, 8'hc5);
		swing(5'd2);
		chk({7'h00, reset_req}, 8'h01);
		repeat (10) @(posedge clock);
		chk({7'h00, reset_req}, 8'h00);
		// mid-run reset, then settling delay before level follows
		@(posedge clock) sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		rchk(STATUS_ADDR, 8'h02);
		rchk(LEVEL_ADDR, {4'h0, LEVEL_RESET});
		wr(PROTECT_ADDR, 8'h08);
		wr(CTRL_ZERO_ADDR, 8'h04);
		wr(CMP_CTRL_ADDR, 8'h20);
		rchk(STATUS_ADDR, 8'h02);
		repeat (12) @(posedge clock);
		rchk(STATUS_ADDR, 8'h00);
		end_of_test();
	end
endmodule
